// *** rtl/faes_host.sv ***
// Function
// - Whole erase sets erase and whole bits.
// - Read block protect after control write.
// - Whole erase armed by any array write.
// - Wait setup time before high voltage on.
// - Hold whole erase at least 4 ms.
// - Clear bits, wait 100 us, drop voltage.
// - No array reads before recovery time.
// - Page erase sets erase, clears whole.
// - Page arming write lands inside page.
// - Hold page erase 1 ms or 4 ms.
// - Clear erase, wait 5 us, drop voltage.
// - Sequence driven from outside the array.
// - Steps in order, no array access between.
// - Sequence should run without interruption.
// - Long page erase for high cycle counts.
//
// The implementer's own choice: the strobed register port.
module faes_host
  import faes_pkg::*;
#(
  parameter int unsigned CNT_W           = CNT_W_D,
  parameter int unsigned WHOLE_ERASE_CNT = WHOLE_ERASE_CYC,
  parameter int unsigned PAGE_SHORT_CNT  = PAGE_SHORT_CYC,
  parameter int unsigned PAGE_LONG_CNT   = PAGE_LONG_CYC,
  parameter int unsigned WHOLE_HOLD_CNT  = WHOLE_HOLD_CYC,
  parameter logic [15:0] WHOLE_ARM_ADDR  = WHOLE_ARM_ADDR_D
) (
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Software register port.
  input  wire logic [3:0]  swAddr,
  input  wire logic [7:0]  swWdata,
  input  wire logic        swWr,
  input  wire logic        swRd,
  output logic      [7:0]  swRdata_r,
  // Device bus.
  output logic      [15:0] devAddr_r,
  output logic      [7:0]  devWdata_r,
  output logic             devWr_r,
  output logic             devRd_r,
  input  wire logic [7:0]  devRdata,
  // Status levels.
  output logic             busy_r
);

  faes_state_t      stateR;
  faes_state_t      stateNxt;
  logic             wholeR;
  logic             longR;
  logic [15:0]      pageR;
  logic             doneR;
  logic             refusedR;
  logic [7:0]       protR;
  logic             devWrNxt;
  logic             devRdNxt;
  logic [15:0]      devAddrNxt;
  logic [7:0]       devWdataNxt;
  logic             tmrLoad;
  logic [CNT_W-1:0] tmrCount;
  logic             doneSet;
  logic             refuseSet;
  logic             protCatch;

  faes_timer_if #(.CNT_W(CNT_W)) tmr ();

  // Software port decode.
  wire       idle      = (stateR == S_IDLE);
  wire       wrCmd     = swWr && (swAddr == SW_CMD);
  wire       wrPageLo  = swWr && (swAddr == SW_PAGE_LO) && idle;
  wire       wrPageHi  = swWr && (swAddr == SW_PAGE_HI) && idle;
  wire       wrStatus  = swWr && (swAddr == SW_STATUS);
  wire       startReq  = wrCmd && swWdata[CMD_START] && idle;
  wire       cmdTake   = wrCmd && idle;
  wire       clrDone   = wrStatus && swWdata[ST_DONE];
  wire       clrRefuse = wrStatus && swWdata[ST_REFUSED];

  // Read data selection; unmapped offsets read as zero.
  wire [7:0] cmdView   = {5'h00, longR, wholeR, 1'b0};
  wire [7:0] statView  = {5'h00, refusedR, doneR, busy_r};
  wire [7:0] rdMux     = (swAddr == SW_CMD)     ? cmdView      :
                         (swAddr == SW_PAGE_LO) ? pageR[7:0]   :
                         (swAddr == SW_PAGE_HI) ? pageR[15:8]  :
                         (swAddr == SW_STATUS)  ? statView     :
                         (swAddr == SW_PROT)    ? protR        : 8'h00;

  // Control words for the device: erase with or without whole array.
  wire [7:0] eraseWord = CTRL_ERASE_M | (wholeR ? CTRL_WHOLE_M : CTRL_OFF);
  wire [7:0] hvWord    = eraseWord | CTRL_HV_M;

  // Arming address: a fixed array word, or the base of the chosen page.
  wire [15:0] pageBase = {pageR[15:PAGE_LSB], {PAGE_LSB{1'b0}}};
  wire [15:0] armAddr  = wholeR ? WHOLE_ARM_ADDR : pageBase;

  // The block protect value that forbids a whole erase.
  wire       protBlocks = wholeR && (devRdata != PROT_ALL_OPEN);

  // Wait lengths chosen by mode; long page erase for many cycles.
  wire [CNT_W-1:0] eraseCnt = wholeR ? CNT_W'(WHOLE_ERASE_CNT) :
                              longR  ? CNT_W'(PAGE_LONG_CNT)   :
                                       CNT_W'(PAGE_SHORT_CNT);
  wire [CNT_W-1:0] holdCnt  = wholeR ? CNT_W'(WHOLE_HOLD_CNT) :
                                       CNT_W'(PAGE_HOLD_CYC);

  // Sequencer: the only source of device bus traffic, one step at a
  // time, so no stray access to the array falls between steps.
  always_comb
  begin
    stateNxt    = stateR;
    devWrNxt    = 1'b0;
    devRdNxt    = 1'b0;
    devAddrNxt  = devAddr_r;
    devWdataNxt = devWdata_r;
    tmrLoad     = 1'b0;
    tmrCount    = '0;
    doneSet     = 1'b0;
    refuseSet   = 1'b0;
    protCatch   = 1'b0;
    case (stateR)
      S_IDLE:
      begin
        if (startReq)
          stateNxt = S_WR_CTRL;
      end
      S_WR_CTRL:
      begin
        devWrNxt    = 1'b1;
        devAddrNxt  = DEV_CTRL_ADDR;
        devWdataNxt = eraseWord;
        stateNxt    = S_RD_PROT;
      end
      S_RD_PROT:
      begin
        devRdNxt    = 1'b1;
        devAddrNxt  = DEV_PROT_ADDR;
        stateNxt    = S_WAIT_RD;
      end
      S_WAIT_RD:
      begin
        stateNxt    = S_CHECK;
      end
      S_CHECK:
      begin
        protCatch   = 1'b1;
        if (protBlocks)
        begin
          refuseSet = 1'b1;
          stateNxt  = S_CLR_HV;
        end
        else
          stateNxt  = S_ARM;
      end
      S_ARM:
      begin
        devWrNxt    = 1'b1;
        devAddrNxt  = armAddr;
        devWdataNxt = ARM_DATA;
        tmrLoad     = 1'b1;
        tmrCount    = CNT_W'(SETUP_CYC);
        stateNxt    = S_W_SETUP;
      end
      S_W_SETUP:
      begin
        if (tmr.expired)
          stateNxt  = S_SET_HV;
      end
      S_SET_HV:
      begin
        devWrNxt    = 1'b1;
        devAddrNxt  = DEV_CTRL_ADDR;
        devWdataNxt = hvWord;
        tmrLoad     = 1'b1;
        tmrCount    = eraseCnt;
        stateNxt    = S_W_ERASE;
      end
      S_W_ERASE:
      begin
        if (tmr.expired)
          stateNxt  = S_CLR_ER;
      end
      S_CLR_ER:
      begin
        devWrNxt    = 1'b1;
        devAddrNxt  = DEV_CTRL_ADDR;
        devWdataNxt = CTRL_HV_M;
        tmrLoad     = 1'b1;
        tmrCount    = holdCnt;
        stateNxt    = S_W_HOLD;
      end
      S_W_HOLD:
      begin
        if (tmr.expired)
          stateNxt  = S_CLR_HV;
      end
      S_CLR_HV:
      begin
        devWrNxt    = 1'b1;
        devAddrNxt  = DEV_CTRL_ADDR;
        devWdataNxt = CTRL_OFF;
        tmrLoad     = 1'b1;
        tmrCount    = CNT_W'(RECOVERY_CYC);
        stateNxt    = S_W_RECOV;
      end
      S_W_RECOV:
      begin
        if (tmr.expired)
        begin
          doneSet   = 1'b1;
          stateNxt  = S_IDLE;
        end
      end
      default:
      begin
        stateNxt    = S_IDLE;
      end
    endcase
  end

  // Wait timer hookup.
  assign tmr.load  = tmrLoad;
  assign tmr.count = tmrCount;

  faes_wait_timer #(.CNT_W(CNT_W)) u_timer (
    .clk   (clk),
    .rst_n (rst_n),
    .tb    (tmr)
  );

  // State and busy; busy stays up until recovery has passed, so software
  // never reads the array early. Only reset can preempt the walk.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      stateR <= S_IDLE;
      busy_r <= 1'b0;
    end
    else
    begin
      stateR <= stateNxt;
      busy_r <= (stateNxt != S_IDLE);
    end
  end

  // Device bus outputs, all registered.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      devWr_r    <= 1'b0;
      devRd_r    <= 1'b0;
      devAddr_r  <= 16'h0000;
      devWdata_r <= 8'h00;
    end
    else
    begin
      devWr_r    <= devWrNxt;
      devRd_r    <= devRdNxt;
      devAddr_r  <= devAddrNxt;
      devWdata_r <= devWdataNxt;
    end
  end

  // Command fields, only taken while idle.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      wholeR <= 1'b0;
      longR  <= 1'b0;
    end
    else if (cmdTake)
    begin
      wholeR <= swWdata[CMD_WHOLE];
      longR  <= swWdata[CMD_LONG];
    end
  end

  // Target page address, only taken while idle.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      pageR <= 16'h0000;
    else if (wrPageLo)
      pageR[7:0] <= swWdata;
    else if (wrPageHi)
      pageR[15:8] <= swWdata;
  end

  // Sticky flags: a set in the same cycle as a clear wins.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      doneR    <= 1'b0;
      refusedR <= 1'b0;
    end
    else
    begin
      doneR    <= doneSet | (doneR & ~(clrDone | startReq));
      refusedR <= refuseSet | (refusedR & ~(clrRefuse | startReq));
    end
  end

  // Last block protect value seen.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      protR <= 8'h00;
    else if (protCatch)
      protR <= devRdata;
  end

  // Read data stand only in the cycle after the read strobe.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      swRdata_r <= 8'h00;
    else
      swRdata_r <= swRd ? rdMux : 8'h00;
  end

  // Cycles since the last device write, saturating; checks only.
  logic [CNT_W-1:0] sinceWr;
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      sinceWr <= '0;
    else if (devWr_r)
      sinceWr <= CNT_W'(1);
    else if (sinceWr != '1)
      sinceWr <= sinceWr + CNT_W'(1);
  end

  // Kinds of device write seen on the bus.
  wire ctrlWr  = devWr_r && (devAddr_r == DEV_CTRL_ADDR);
  wire hvOnWr  = ctrlWr && |(devWdata_r & CTRL_HV_M)
                 && |(devWdata_r & CTRL_ERASE_M);
  wire ersClr  = ctrlWr && (devWdata_r == CTRL_HV_M);
  wire allOff  = ctrlWr && (devWdata_r == CTRL_OFF);
  wire armWr   = devWr_r && (devAddr_r != DEV_CTRL_ADDR);

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  chk_ctrl_first: assert property (
    $rose(busy_r) |=> ctrlWr && ((devWdata_r & ~CTRL_HV_M) == eraseWord))
    else $error("first step is not the erase control write");

  chk_prot_read: assert property (
    $rose(busy_r) |=> ##1 (devRd_r && (devAddr_r == DEV_PROT_ADDR)))
    else $error("block protect not read second");

  chk_refuse_path: assert property (
    (stateR == S_CHECK) && protBlocks |->
      !armWr ##[1:3] allOff)
    else $error("protected whole erase was not refused");

  chk_setup_wait: assert property (
    hvOnWr |-> (sinceWr >= SETUP_CYC))
    else $error("high voltage set before setup time");

  chk_erase_hold: assert property (
    ersClr |-> (sinceWr >= eraseCnt) && !refusedR)
    else $error("erase bits cleared too early");

  chk_hold_after: assert property (
    allOff && !refusedR |-> (sinceWr >= holdCnt))
    else $error("high voltage dropped too early");

  chk_recovery: assert property (
    $fell(busy_r) |-> (sinceWr >= RECOVERY_CYC) && doneR)
    else $error("busy dropped before recovery time");

  chk_arm_page: assert property (
    armWr |-> (devAddr_r == armAddr) && (devWdata_r == ARM_DATA))
    else $error("arming write outside the target");

  chk_one_strobe: assert property (
    (devWr_r || devRd_r) |-> busy_r && !(devWr_r && devRd_r))
    else $error("stray or double device bus strobe");

endmodule : faes_host

// *** include/faes_pkg.sv ***
package faes_pkg;

  // System clock period in nanoseconds.
  localparam int unsigned CLK_NS = 20;

  // Least times of the erase walk, in nanoseconds.
  localparam int unsigned SETUP_BEFORE_HV_NS        = 10000;
  localparam int unsigned WHOLE_ARRAY_ERASE_TIME_NS = 4000000;
  localparam int unsigned PAGE_ERASE_SHORT_NS       = 1000000;
  localparam int unsigned PAGE_ERASE_LONG_NS        = 4000000;
  localparam int unsigned WHOLE_ARRAY_HOLD_AFTER_NS = 100000;
  localparam int unsigned PAGE_HOLD_AFTER_NS        = 5000;
  localparam int unsigned READ_RECOVERY_TIME_NS     = 1000;

  // Rounds a least time up to whole clock cycles.
  function automatic int unsigned faes_cyc(input int unsigned ns);
    return (ns + CLK_NS - 1) / CLK_NS;
  endfunction : faes_cyc

  // Cycle counts derived from the times above.
  localparam int unsigned SETUP_CYC       = faes_cyc(SETUP_BEFORE_HV_NS);
  localparam int unsigned WHOLE_ERASE_CYC = faes_cyc(WHOLE_ARRAY_ERASE_TIME_NS);
  localparam int unsigned PAGE_SHORT_CYC  = faes_cyc(PAGE_ERASE_SHORT_NS);
  localparam int unsigned PAGE_LONG_CYC   = faes_cyc(PAGE_ERASE_LONG_NS);
  localparam int unsigned WHOLE_HOLD_CYC  = faes_cyc(WHOLE_ARRAY_HOLD_AFTER_NS);
  localparam int unsigned PAGE_HOLD_CYC   = faes_cyc(PAGE_HOLD_AFTER_NS);
  localparam int unsigned RECOVERY_CYC    = faes_cyc(READ_RECOVERY_TIME_NS);

  // Width of the wait counter; holds the longest count.
  localparam int unsigned CNT_W_D = 18;

  // Device registers on the device bus.
  localparam logic [15:0] DEV_PROT_ADDR = 16'hFF80;
  localparam logic [15:0] DEV_CTRL_ADDR = 16'hFF88;

  // Device control bit masks and data values.
  localparam logic [7:0] CTRL_ERASE_M  = 8'h02;
  localparam logic [7:0] CTRL_WHOLE_M  = 8'h04;
  localparam logic [7:0] CTRL_HV_M     = 8'h08;
  localparam logic [7:0] CTRL_OFF      = 8'h00;
  localparam logic [7:0] ARM_DATA      = 8'h00;
  localparam logic [7:0] PROT_ALL_OPEN = 8'hFF;

  // Page geometry and the default arming address for a whole erase.
  localparam int unsigned PAGE_LSB         = 7;
  localparam logic [15:0] WHOLE_ARM_ADDR_D = 16'h8000;

  // Controller register offsets on the software port.
  localparam logic [3:0] SW_CMD     = 4'h0;
  localparam logic [3:0] SW_PAGE_LO = 4'h1;
  localparam logic [3:0] SW_PAGE_HI = 4'h2;
  localparam logic [3:0] SW_STATUS  = 4'h3;
  localparam logic [3:0] SW_PROT    = 4'h4;

  // Field positions in the command and status registers.
  localparam int unsigned CMD_START  = 0;
  localparam int unsigned CMD_WHOLE  = 1;
  localparam int unsigned CMD_LONG   = 2;
  localparam int unsigned ST_BUSY    = 0;
  localparam int unsigned ST_DONE    = 1;
  localparam int unsigned ST_REFUSED = 2;

  // Sequencer states, Gray coded along the walk.
  typedef enum logic [3:0] {
    S_IDLE    = 4'h0,
    S_WR_CTRL = 4'h1,
    S_RD_PROT = 4'h3,
    S_WAIT_RD = 4'h2,
    S_CHECK   = 4'h6,
    S_ARM     = 4'h7,
    S_W_SETUP = 4'h5,
    S_SET_HV  = 4'h4,
    S_W_ERASE = 4'hC,
    S_CLR_ER  = 4'hD,
    S_W_HOLD  = 4'hF,
    S_CLR_HV  = 4'hE,
    S_W_RECOV = 4'hA
  } faes_state_t;

endpackage : faes_pkg

// *** include/faes_timer_if.sv ***
interface faes_timer_if #(parameter int unsigned CNT_W = 18);

  // Load pulse with its count, and the expiry pulse.
  logic             load;
  logic [CNT_W-1:0] count;
  logic             expired;

  modport ctl (output load, output count, input expired);
  modport tmr (input load, input count, output expired);

endinterface : faes_timer_if

// *** rtl/faes_wait_timer.sv ***
module faes_wait_timer #(
  parameter int unsigned CNT_W = 18
) (
  // Clock and reset.
  input wire logic   clk,
  input wire logic   rst_n,
  // Load and expiry.
  faes_timer_if.tmr  tb
);

  localparam logic [CNT_W-1:0] ONE = CNT_W'(1);

  logic [CNT_W-1:0] cntR;
  logic             runR;
  logic             expR;

  // Counts down a loaded value and pulses expiry after that many cycles.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      cntR <= '0;
      runR <= 1'b0;
      expR <= 1'b0;
    end
    else if (tb.load)
    begin
      cntR <= tb.count;
      runR <= 1'b1;
      expR <= 1'b0;
    end
    else if (runR)
    begin
      cntR <= cntR - ONE;
      runR <= (cntR != ONE);
      expR <= (cntR == ONE);
    end
    else
    begin
      expR <= 1'b0;
    end
  end

  // Expiry leaves straight from its flip-flop.
  assign tb.expired = expR;

endmodule : faes_wait_timer

// *** verif/faes_dev_model.sv ***
module faes_dev_model
  import faes_pkg::*;
(
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Device bus from the controller.
  input  wire logic [15:0] devAddr,
  input  wire logic [7:0]  devWdata,
  input  wire logic        devWr,
  input  wire logic        devRd,
  output logic      [7:0]  devRdata,
  // Protect value taken at reset, and tallies.
  input  wire logic [7:0]  protInit,
  output int               hvCount,
  output int               badCount
);
  logic [7:0] prot_r;
  logic [7:0] ctrl_r;
  logic       armed_r;
  logic       inArray;
  logic       eraseOn;
  logic       hvOn;

  // Array space is the upper half, bar the two register locations.
  assign inArray = devAddr[15] && devAddr != DEV_PROT_ADDR
                   && devAddr != DEV_CTRL_ADDR;
  assign eraseOn = |(ctrl_r & CTRL_ERASE_M);
  // Voltage reaches the cells only when armed, and for a whole erase only when not protected.
  assign hvOn = |(ctrl_r & CTRL_HV_M) && eraseOn && armed_r
                && (!(|(ctrl_r & CTRL_WHOLE_M))
                || prot_r == PROT_ALL_OPEN);

  // Registers, arming latch, read port and tallies.
  always @(posedge clk)
  begin
    devRdata <= ~devRdata;
    if (!rst_n)
    begin
      prot_r   <= protInit;
      ctrl_r   <= CTRL_OFF;
      armed_r  <= 1'b0;
      devRdata <= 8'h00;
      hvCount  <= 0;
      badCount <= 0;
    end
    else
    begin
      if (hvOn)
        hvCount <= hvCount + 1;
      if (devRd)
        devRdata <= devAddr == DEV_PROT_ADDR ? prot_r : ctrl_r;
      if (devWr && devAddr == DEV_PROT_ADDR)
        prot_r <= devWdata;
      if (devWr && devAddr == DEV_CTRL_ADDR)
        ctrl_r <= devWdata;
      if (devWr && devAddr == DEV_CTRL_ADDR && !(|(devWdata & CTRL_ERASE_M)))
        armed_r <= 1'b0;
      if (devWr && inArray)
        armed_r <= eraseOn;
      if ((devWr || devRd) && inArray && (!eraseOn || armed_r))
        badCount <= badCount + 1;
    end
  end
endmodule : faes_dev_model

// *** verif/tb.sv ***
module tb
  import faes_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  localparam int unsigned WE = 40;
  localparam int unsigned PS = 20;
  localparam int unsigned PL = 30;
  localparam int unsigned WH = 10;

  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [3:0]  swAddr = 4'h0;
  logic [7:0]  swWdata = 8'h00;
  logic        swWr = 1'b0;
  logic        swRd = 1'b0;
  logic [7:0]  swRdata_r;
  logic [15:0] devAddr_r;
  logic [7:0]  devWdata_r;
  logic        devWr_r;
  logic        devRd_r;
  logic [7:0]  devRdata;
  logic        busy_r;
  logic [7:0]  protInit = 8'hFF;
  int          hvCount;
  int          badCount;
  int          num_errors = 0;
  int          check_count = 0;
  int          seed = 32'h532B4851;
  int          cyc = 0;
  logic [15:0] wA[$];
  logic [7:0]  wD[$];
  int          wC[$];
  logic [15:0] rA[$];
  int          rC[$];

  // Free-running clock.
  always #10 clk = ~clk;

  faes_host #(.WHOLE_ERASE_CNT(WE), .PAGE_SHORT_CNT(PS),
    .PAGE_LONG_CNT(PL), .WHOLE_HOLD_CNT(WH)) u_faes_host (
    .clk(clk), .rst_n(rst_n), .swAddr(swAddr), .swWdata(swWdata),
    .swWr(swWr), .swRd(swRd), .swRdata_r(swRdata_r),
    .devAddr_r(devAddr_r), .devWdata_r(devWdata_r), .devWr_r(devWr_r),
    .devRd_r(devRd_r), .devRdata(devRdata), .busy_r(busy_r));

  faes_dev_model u_faes_dev_model (
    .clk(clk), .rst_n(rst_n), .devAddr(devAddr_r), .devWdata(devWdata_r),
    .devWr(devWr_r), .devRd(devRd_r), .devRdata(devRdata),
    .protInit(protInit), .hvCount(hvCount), .badCount(badCount));

  // Logs device strobes with the cycle they stand in.
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (devWr_r)
    begin
      wA.push_back(devAddr_r);
      wD.push_back(devWdata_r);
      wC.push_back(cyc);
    end
    if (devRd_r)
    begin
      rA.push_back(devAddr_r);
      rC.push_back(cyc);
    end
  end

  // Compares a seen value with the expected one.
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Prints the counts and the verdict, then stops.
  task automatic end_of_test();
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : end_of_test

  // Erase hold in cycles for a command, from the bench's own counts.
  function automatic int eraseCycles(input logic [7:0] cmd);
    if (cmd[CMD_WHOLE])
      return WE;
    return cmd[CMD_LONG] ? PL : PS;
  endfunction : eraseCycles

  // One-cycle software write.
  task automatic swWrite(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    swAddr <= a;
    swWdata <= d;
    swWr <= 1'b1;
    @(posedge clk);
    swWr <= 1'b0;
  endtask : swWrite

  // One-cycle software read; data stands in the next cycle.
  task automatic swRead(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    swAddr <= a;
    swRd <= 1'b1;
    @(posedge clk);
    swRd <= 1'b0;
    #1;
    check({8'h00, swRdata_r}, {8'h00, e});
  endtask : swRead

  // Holds reset for eight cycles with a given protect value.
  task automatic doReset(input logic [7:0] p);
    @(posedge clk);
    protInit <= p;
    rst_n <= 1'b0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
  endtask : doReset

  // Waits, bounded, for the sequence to finish.
  task automatic waitIdle();
    int n;
    n = 0;
    #1;
    while (busy_r !== 1'b0)
    begin
      @(posedge clk);
      #1;
      n++;
      if (n > 2000)
      begin
        check(16'h0000, 16'h0001);
        end_of_test();
      end
    end
  endtask : waitIdle

  // Runs one erase and checks the device bus walk and the status.
  task automatic runOp(input logic [7:0] cmd, input logic [15:0] page,
                       input logic refuse);
    logic [15:0] eA[5];
    logic [7:0]  eD[5];
    int          eG[5];
    logic [7:0]  ctl;
    int          h0;
    int          cnt;
    int          n;
    int          k;
    cnt = eraseCycles(cmd);
    ctl = CTRL_ERASE_M | (cmd[CMD_WHOLE] ? CTRL_WHOLE_M : 8'h00);
    eA = '{DEV_CTRL_ADDR, cmd[CMD_WHOLE] ? WHOLE_ARM_ADDR_D
           : page & 16'hFF80, DEV_CTRL_ADDR, DEV_CTRL_ADDR, DEV_CTRL_ADDR};
    eD = '{ctl, ARM_DATA, ctl | CTRL_HV_M, CTRL_HV_M, CTRL_OFF};
    eG = '{0, 4, SETUP_CYC + 2, cnt + 2,
           (cmd[CMD_WHOLE] ? WH : PAGE_HOLD_CYC) + 2};
    n = refuse ? 2 : 5;
    if (refuse)
    begin
      eA[1] = DEV_CTRL_ADDR;
      eD[1] = CTRL_OFF;
      eG[1] = 4;
    end
    wA.delete();
    wD.delete();
    wC.delete();
    rA.delete();
    rC.delete();
    swWrite(SW_PAGE_LO, page[7:0]);
    swWrite(SW_PAGE_HI, page[15:8]);
    h0 = hvCount;
    swWrite(SW_CMD, cmd);
    swWrite(SW_CMD, cmd);
    swWrite(SW_PAGE_LO, ~page[7:0]);
    waitIdle();
    check(16'(wA.size()), 16'(n));
    for (k = 0; k < n; k++)
    begin
      check(wA[k], eA[k]);
      check({8'h00, wD[k]}, {8'h00, eD[k]});
      if (k > 0)
        check(16'(wC[k] - wC[k-1]), 16'(eG[k]));
    end
    check(16'(cyc - wC[n-1]), 16'(RECOVERY_CYC + 1));
    check(rA[0], DEV_PROT_ADDR);
    check(16'(rC[0] - wC[0]), 16'h0001);
    check(16'(hvCount - h0), refuse ? 16'h0000 : 16'(cnt + 2));
    swRead(SW_STATUS, refuse ? 8'h06 : 8'h02);
    swRead(SW_CMD, cmd & 8'h06);
    swRead(SW_PAGE_LO, page[7:0]);
  endtask : runOp

  // Main sequence.
  initial
  begin
    logic [15:0] pg;
    logic [7:0]  p;
    int          i;
    doReset(8'hFF);
    for (i = 0; i < 8; i++)
      swRead(4'(i), 8'h00);
    for (i = 0; i < 4; i++)
    begin
      pg = 16'h8000 | (16'($random(seed)) & 16'h3FFF);
      if (i == 0)
        pg = 16'h807F;
      runOp({5'h00, i[0], 2'b01}, pg, 1'b0);
    end
    runOp(8'h03, 16'h0000, 1'b0);
    swWrite(SW_STATUS, 8'h06);
    swRead(SW_STATUS, 8'h00);
    p = 8'($random(seed)) & 8'hFE;
    doReset(p);
    runOp(8'h03, 16'h0000, 1'b1);
    swRead(SW_PROT, p);
    swWrite(SW_CMD, 8'h01);
    repeat (20) @(posedge clk);
    doReset(8'hFF);
    #1;
    check({15'h0000, busy_r}, 16'h0000);
    check({8'h00, u_faes_dev_model.ctrl_r}, 16'h0000);
    swRead(SW_STATUS, 8'h00);
    swRead(SW_PAGE_LO, 8'h00);
    check(16'(badCount), 16'h0000);
    end_of_test();
  end
endmodule : tb
